// File: core/cmd_enable_defines.svh
`ifndef CMD_ENABLE_DEFINES_SVH
`define CMD_ENABLE_DEFINES_SVH

// Command byte layout.
`define CMD_SELECT_BIT      7
`define CMD_TYPE_HI         6
`define CMD_TYPE_LO         5
`define CMD_ADD_HI          4
`define CMD_ADD_LO          0

// Transaction type codes.
`define TYPE_REPEAT         2'h0
`define TYPE_AUTO_INC       2'h1
`define TYPE_RESERVED       2'h2
`define TYPE_SPECIAL        2'h3

// Special function codes.
`define SF_NOP              5'h00
`define SF_PROX_CLEAR       5'h05
`define SF_LIGHT_CLEAR      5'h06
`define SF_BOTH_CLEAR       5'h07

// Function enable register.
`define FUNC_ENABLE_ADDR    5'h00
`define FUNC_ENABLE_RESET   8'h00
`define FUNC_ENABLE_WMASK   8'h3f
`define EN_PROX_IRQ_MASK    5
`define EN_LIGHT_IRQ_MASK   4
`define EN_WAIT             3
`define EN_PROX_FUNC        2
`define EN_LIGHT_FUNC       1
`define EN_OSC_POWER_ON     0

// Command pointer reset value.
`define CMD_PTR_RESET       5'h00

// Bus address of the device; the value is arbitrary.
`define BUS_DEV_ADDR        7'h2a

// Power-on settling time.
`define CLK_PERIOD_NS       4
`define PON_DELAY_NS        2720000
`define PON_DELAY_CYCLES    ((`PON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/cmd_enable_pkg.sv
package cmd_enable_pkg;

	typedef enum logic [6:0] {
		ENG_IDLE      = 7'b0000001,
		ENG_ADDR      = 7'b0000010,
		ENG_ADDR_ACK  = 7'b0000100,
		ENG_WRITE     = 7'b0001000,
		ENG_WRITE_ACK = 7'b0010000,
		ENG_READ      = 7'b0100000,
		ENG_READ_ACK  = 7'b1000000
	} eng_state_type;

	typedef enum logic [2:0] {
		SEQ_SLEEP  = 3'b001,
		SEQ_WARMUP = 3'b010,
		SEQ_RUN    = 3'b100
	} seq_state_type;

	typedef logic [1:0] xfer_type_type;

endpackage

// File: core/serial_byte_engine.sv
`timescale 1ns/1ns
`include "cmd_enable_defines.svh"

module serial_byte_engine (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_oe_o,
	output logic            wr_valid_o,
	output logic            wr_first_o,
	output logic [7:0]      wr_byte_o,
	output logic            rd_done_o,
	input  wire logic [7:0] rd_data_i
);
	import cmd_enable_pkg::*;

	logic          scl_m_q, scl_s_q, scl_p_q;
	logic          sda_m_q, sda_s_q, sda_p_q;
	logic          scl_rise, scl_fall, start_cond, stop_cond;
	eng_state_type state_q, state_d;
	logic [3:0]    cnt_q, cnt_d;
	logic [7:0]    sh_q, sh_d;
	logic          oe_q, oe_d, rw_q, rw_d, first_q, first_d;
	logic          wr_valid_d, wr_first_d, rd_done_d;

	// Two-stage synchronisers, then a third stage for edge detection.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end else begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
		end
	end

	// Bus events seen on the synchronised lines.
	assign scl_rise   = scl_s_q & ~scl_p_q;
	assign scl_fall   = ~scl_s_q & scl_p_q;
	assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// Byte framing: address, acknowledge, data in and data out.
	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		oe_d       = oe_q;
		rw_d       = rw_q;
		first_d    = first_q;
		wr_valid_d = 1'b0;
		wr_first_d = first_q;
		rd_done_d  = 1'b0;
		if (stop_cond) begin
			state_d = ENG_IDLE;
			oe_d    = 1'b0;
		end else if (start_cond) begin
			state_d = ENG_ADDR;
			cnt_d   = 4'h0;
			oe_d    = 1'b0;
		end else begin
			unique case (state_q)
				ENG_IDLE: begin
				end
				ENG_ADDR, ENG_WRITE: begin
					if (scl_rise && cnt_q < 4'h8) begin
						sh_d  = {sh_q[6:0], sda_s_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == ENG_ADDR) begin
							if (sh_q[7:1] == `BUS_DEV_ADDR) begin
								rw_d    = sh_q[0];
								first_d = 1'b1;
								oe_d    = 1'b1;
								state_d = ENG_ADDR_ACK;
							end else begin
								state_d = ENG_IDLE;
							end
						end else begin
							wr_valid_d = 1'b1;
							oe_d       = 1'b1;
							state_d    = ENG_WRITE_ACK;
						end
					end
				end
				ENG_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							sh_d    = rd_data_i;
							oe_d    = ~rd_data_i[7];
							state_d = ENG_READ;
						end else begin
							oe_d    = 1'b0;
							state_d = ENG_WRITE;
						end
					end
				end
				ENG_WRITE_ACK: begin
					if (scl_fall) begin
						oe_d    = 1'b0;
						cnt_d   = 4'h0;
						first_d = 1'b0;
						state_d = ENG_WRITE;
					end
				end
				ENG_READ: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							oe_d      = 1'b0;
							rd_done_d = 1'b1;
							state_d   = ENG_READ_ACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6];
						end
					end
				end
				ENG_READ_ACK: begin
					if (scl_rise && sda_s_q) begin
						state_d = ENG_IDLE; // Host refused: stop sending.
					end else if (scl_fall) begin
						sh_d    = rd_data_i;
						oe_d    = ~rd_data_i[7];
						cnt_d   = 4'h0;
						state_d = ENG_READ;
					end
				end
			endcase
		end
	end

	// Framing registers.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q    <= ENG_IDLE;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			oe_q       <= 1'b0;
			rw_q       <= 1'b0;
			first_q    <= 1'b0;
			wr_valid_o <= 1'b0;
			wr_first_o <= 1'b0;
			rd_done_o  <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			oe_q       <= oe_d;
			rw_q       <= rw_d;
			first_q    <= first_d;
			wr_valid_o <= wr_valid_d;
			wr_first_o <= wr_first_d;
			rd_done_o  <= rd_done_d;
		end
	end

	assign sda_oe_o  = oe_q;
	assign wr_byte_o = sh_q;

endmodule

// File: core/cmd_enable_ctrl.sv
// Operation
// - Type 00: data accesses stay on one register, pointer unchanged.
// - Type 01: pointer advances after every data byte.
// - Type 11: low five bits are a special function code.
// - Other types: low five bits load the register pointer.
// - Codes 00000 nothing, 00101 proximity clear, 00110 light clear, 00111 both.
// - An interrupt clear acts once and needs no later write.
// - Proximity interrupt reaches the host only with its mask bit 5 set.
// - Light interrupt reaches the host only with its mask bit 4 set.
// - Enable bit 3 turns the wait timer on and off.
// - Enable bit 2 turns proximity measurement on and off.
// - Enable bit 1 turns the two-channel light converter on and off.
// - Enable bit 0 starts and stops the internal oscillator.
// - A non-command data byte is stored at the current pointer address.
// - A raised interrupt holds until its matching clear command.
// - Measurements wait at least 2.72 ms after power-on is set.
// - The enable register resets to zero.
`timescale 1ns/1ns
`include "cmd_enable_defines.svh"

module cmd_enable_ctrl #(
	parameter int unsigned PON_DELAY_CYCLES = `PON_DELAY_CYCLES
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       prox_event_i,
	input  wire logic       light_event_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic [4:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	output logic            reg_wr_o,
	output logic            oscillator_power_on_o,
	output logic            light_function_enable_o,
	output logic            prox_function_enable_o,
	output logic            wait_enable_o,
	output logic            ambient_light_measure_o,
	output logic            prox_measure_o,
	output logic            sequencer_sleep_o,
	output logic            prox_irq_pending_o,
	output logic            light_irq_pending_o,
	output logic            int_n_o,
	output cmd_enable_pkg::xfer_type_type xfer_type_o
);
	import cmd_enable_pkg::*;

	// Last value of the warm-up counter before the sequencer may run.
	localparam logic [19:0] PON_LAST = 20'(PON_DELAY_CYCLES - 1);

	logic          wr_valid, wr_first, rd_done, eng_sda_oe;
	logic [7:0]    wr_byte, rd_data;
	logic [4:0]    ptr_q, ptr_d;
	xfer_type_type type_q, type_d;
	logic [7:0]    enable_q, enable_d;
	logic [7:0]    wdata_q, wdata_d;
	logic          ext_wr_q, ext_wr_d;
	logic          adv_q, adv_d;
	logic          clr_prox, clr_light;
	logic          prox_pend_q, prox_pend_d, light_pend_q, light_pend_d;
	logic          int_n_q, int_n_d;
	seq_state_type seq_q, seq_d;
	logic [19:0]   warm_cnt_q, warm_cnt_d;
	logic          light_meas_q, light_meas_d, prox_meas_q, prox_meas_d;

	// Next pointer value for one data byte, by transaction type.
	// Type 10 is reserved; it falls through here and behaves like type 00.
	function automatic logic [4:0] step_ptr(input logic [4:0] ptr, input xfer_type_type t);
		logic [4:0] nxt;
		nxt = ptr;
		if (t == `TYPE_AUTO_INC) begin
			nxt = ptr + 5'h01;
		end
		return nxt;
	endfunction

	// Serial byte framing and pin handling. The pins are synchronised inside,
	// so every bus event reaches this level three cycles after the pin moves.
	serial_byte_engine u_engine (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_oe_o   (eng_sda_oe),
		.wr_valid_o (wr_valid),
		.wr_first_o (wr_first),
		.wr_byte_o  (wr_byte),
		.rd_done_o  (rd_done),
		.rd_data_i  (rd_data)
	);

	// Read data: the enable register lives here, all others outside.
	// The engine copies this value on an SCL fall, long after the pointer settles.
	assign rd_data = (ptr_q == `FUNC_ENABLE_ADDR) ? enable_q : reg_rdata_i;

	// Command decode, pointer, enable register and outside writes.
	// Only the first byte after the address may be a command; later bytes are data.
	always_comb begin
		ptr_d     = ptr_q;
		type_d    = type_q;
		enable_d  = enable_q;
		wdata_d   = wdata_q;
		ext_wr_d  = 1'b0;
		adv_d     = 1'b0;
		clr_prox  = 1'b0;
		clr_light = 1'b0;
		// step after the write
		// The pointer moves one cycle after a data byte, so that the outside
		// write pulse still carries the address that its byte belongs to.
		if (adv_q) begin
			ptr_d = step_ptr(ptr_q, type_q);
		end
		if (wr_valid) begin
			if (wr_first && wr_byte[`CMD_SELECT_BIT]) begin
				if (wr_byte[`CMD_TYPE_HI:`CMD_TYPE_LO] == `TYPE_SPECIAL) begin
					unique case (wr_byte[`CMD_ADD_HI:`CMD_ADD_LO])
						`SF_PROX_CLEAR: begin
							clr_prox = 1'b1;
						end
						`SF_LIGHT_CLEAR: begin
							clr_light = 1'b1;
						end
						`SF_BOTH_CLEAR: begin
							clr_prox  = 1'b1;
							clr_light = 1'b1;
						end
						default: begin
						end
					endcase
				end else begin
					ptr_d  = wr_byte[`CMD_ADD_HI:`CMD_ADD_LO];
					type_d = wr_byte[`CMD_TYPE_HI:`CMD_TYPE_LO];
				end
			end else begin
				if (ptr_q == `FUNC_ENABLE_ADDR) begin
					enable_d = wr_byte & `FUNC_ENABLE_WMASK;
				end else begin
					wdata_d  = wr_byte;
					ext_wr_d = 1'b1;
				end
				adv_d = 1'b1;
			end
		end else if (rd_done) begin
			ptr_d = step_ptr(ptr_q, type_q);
		end
	end

	// Register file state. Only the enable register is held here; the other
	// registers sit outside and see one write pulse per data byte.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ptr_q    <= `CMD_PTR_RESET;
			type_q   <= `TYPE_REPEAT;
			enable_q <= `FUNC_ENABLE_RESET;
			wdata_q  <= 8'h00;
			ext_wr_q <= 1'b0;
			adv_q    <= 1'b0;
		end else begin
			ptr_q    <= ptr_d;
			type_q   <= type_d;
			enable_q <= enable_d;
			wdata_q  <= wdata_d;
			ext_wr_q <= ext_wr_d;
			adv_q    <= adv_d;
		end
	end

	// Pending interrupts: a masked event sets, a clear command resets, set wins.
	// Letting the set win means an event that lands on the clear cycle is
	// never lost; the host simply sees the interrupt again.
	always_comb begin
		prox_pend_d  = prox_pend_q;
		light_pend_d = light_pend_q;
		if (clr_prox) begin
			prox_pend_d = 1'b0;
		end
		if (clr_light) begin
			light_pend_d = 1'b0;
		end
		if (prox_event_i && enable_q[`EN_PROX_IRQ_MASK]) begin
			prox_pend_d = 1'b1;
		end
		if (light_event_i && enable_q[`EN_LIGHT_IRQ_MASK]) begin
			light_pend_d = 1'b1;
		end
		int_n_d = ~((prox_pend_d & enable_q[`EN_PROX_IRQ_MASK]) |
			(light_pend_d & enable_q[`EN_LIGHT_IRQ_MASK]));
	end

	// Interrupt state.
	// The interrupt pin is registered so that it never glitches while flags change.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prox_pend_q  <= 1'b0;
			light_pend_q <= 1'b0;
			int_n_q      <= 1'b1;
		end else begin
			prox_pend_q  <= prox_pend_d;
			light_pend_q <= light_pend_d;
			int_n_q      <= int_n_d;
		end
	end

	// Measurement gating: sleep, oscillator warm-up, then run.
	// The warm-up is enforced here so that firmware which enables the
	// converters together with power-on still gets a settled oscillator.
	always_comb begin
		seq_d        = seq_q;
		warm_cnt_d   = warm_cnt_q;
		light_meas_d = 1'b0;
		prox_meas_d  = 1'b0;
		unique case (seq_q)
			SEQ_SLEEP: begin
				warm_cnt_d = 20'h00000;
				if (enable_q[`EN_OSC_POWER_ON]) begin
					seq_d = SEQ_WARMUP;
				end
			end
			SEQ_WARMUP: begin
				if (warm_cnt_q >= PON_LAST) begin
					seq_d = SEQ_RUN;
				end else begin
					warm_cnt_d = warm_cnt_q + 20'h00001;
				end
			end
			SEQ_RUN: begin
				light_meas_d = enable_q[`EN_LIGHT_FUNC];
				prox_meas_d  = enable_q[`EN_PROX_FUNC];
			end
		endcase
		if (!enable_q[`EN_OSC_POWER_ON]) begin
			seq_d        = SEQ_SLEEP;
			light_meas_d = 1'b0;
			prox_meas_d  = 1'b0;
		end
	end

	// Sequencer state.
	// The measure outputs are registered, one cycle behind the state.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_q        <= SEQ_SLEEP;
			warm_cnt_q   <= 20'h00000;
			light_meas_q <= 1'b0;
			prox_meas_q  <= 1'b0;
		end else begin
			seq_q        <= seq_d;
			warm_cnt_q   <= warm_cnt_d;
			light_meas_q <= light_meas_d;
			prox_meas_q  <= prox_meas_d;
		end
	end

	// Bus pin drive; the enable comes from the engine's own flip-flop.
	assign sda_o                   = 1'b0; // Open drain: only ever pulls low.
	assign sda_oe_o                = eng_sda_oe;

	// Access toward the outside registers.
	assign reg_addr_o              = ptr_q;
	assign reg_wdata_o             = wdata_q;
	assign reg_wr_o                = ext_wr_q;

	// Enable register bits.
	assign oscillator_power_on_o   = enable_q[`EN_OSC_POWER_ON];
	assign light_function_enable_o = enable_q[`EN_LIGHT_FUNC];
	assign prox_function_enable_o  = enable_q[`EN_PROX_FUNC];
	assign wait_enable_o           = enable_q[`EN_WAIT];

	// Sequencer and interrupt status.
	assign ambient_light_measure_o = light_meas_q;
	assign prox_measure_o          = prox_meas_q;
	assign sequencer_sleep_o       = seq_q[0]; // One-hot code: bit 0 is the sleep state.
	assign prox_irq_pending_o      = prox_pend_q;
	assign light_irq_pending_o     = light_pend_q;
	assign int_n_o                 = int_n_q;
	assign xfer_type_o             = type_q;

endmodule

// File: dv/cmd_enable_ctrl_props.sv
`timescale 1ns/1ns
`include "cmd_enable_defines.svh"

module cmd_enable_ctrl_props #(
	parameter int unsigned PON_DELAY_CYCLES = `PON_DELAY_CYCLES
) (
	input wire logic       ref_clk_i,
	input wire logic       rst_n_i,
	input wire logic       sda_oe_o,
	input wire logic       prox_event_i,
	input wire logic       light_event_i,
	input wire logic [4:0] reg_addr_o,
	input wire logic       reg_wr_o,
	input wire logic       oscillator_power_on_o,
	input wire logic       light_function_enable_o,
	input wire logic       prox_function_enable_o,
	input wire logic       ambient_light_measure_o,
	input wire logic       prox_measure_o,
	input wire logic       sequencer_sleep_o,
	input wire logic       prox_irq_pending_o,
	input wire logic       light_irq_pending_o,
	input wire logic       int_n_o,
	input wire cmd_enable_pkg::xfer_type_type xfer_type_o
);
	import cmd_enable_pkg::*;
	logic [31:0] cnt_d, cnt_q;
	logic [4:0]  wra_d, wra_q;

	// Counts cycles with the oscillator on and keeps the address of the last write.
	always_comb begin
		cnt_d = oscillator_power_on_o ? cnt_q + 32'h1 : 32'h0;
		wra_d = reg_wr_o ? reg_addr_o : wra_q;
	end

	// Registers the helper state.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 32'h0;
			wra_q <= 5'h0;
		end else begin
			cnt_q <= cnt_d;
			wra_q <= wra_d;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	rst_vals_a:
	assert property ($rose(rst_n_i) |-> int_n_o && sequencer_sleep_o && !oscillator_power_on_o
		&& !prox_irq_pending_o) else $error("outputs not at reset values");
	pend_hold_a:
	assert property ($fell(prox_irq_pending_o) || $fell(light_irq_pending_o) |-> ##[0:6] sda_oe_o)
		else $error("pending flag dropped outside a command");
	prox_set_a:
	assert property ($rose(prox_irq_pending_o) |-> $past(prox_event_i) || $past(prox_event_i, 2))
		else $error("proximity pending rose without an event");
	light_set_a:
	assert property ($rose(light_irq_pending_o) |-> $past(light_event_i) || $past(light_event_i, 2))
		else $error("light pending rose without an event");
	int_src_a:
	assert property (!int_n_o |-> prox_irq_pending_o || light_irq_pending_o)
		else $error("interrupt low with nothing pending");
	pon_wait_a:
	assert property (ambient_light_measure_o || prox_measure_o |-> cnt_q >= PON_DELAY_CYCLES)
		else $error("measurement began too soon after power on");
	sleep_off_a:
	assert property ($fell(oscillator_power_on_o) |-> ##2 sequencer_sleep_o
		&& !ambient_light_measure_o && !prox_measure_o) else $error("sequencer kept running");
	light_gate_a:
	assert property (ambient_light_measure_o |-> $past(light_function_enable_o))
		else $error("light measure without its enable");
	prox_gate_a:
	assert property (prox_measure_o |-> $past(prox_function_enable_o))
		else $error("proximity measure without its enable");
	ptr_hold_a:
	assert property (reg_wr_o && xfer_type_o == `TYPE_REPEAT |=> $stable(reg_addr_o) [*8])
		else $error("pointer moved in repeated mode");
	ptr_step_a:
	assert property (reg_wr_o && xfer_type_o == `TYPE_AUTO_INC |-> ##[1:8] reg_addr_o == wra_q + 5'h1)
		else $error("pointer did not advance");
endmodule

bind cmd_enable_ctrl cmd_enable_ctrl_props #(.PON_DELAY_CYCLES(PON_DELAY_CYCLES)) props_u (
	.ref_clk_i, .rst_n_i, .sda_oe_o, .prox_event_i, .light_event_i, .reg_addr_o, .reg_wr_o,
	.oscillator_power_on_o, .light_function_enable_o, .prox_function_enable_o,
	.ambient_light_measure_o, .prox_measure_o, .sequencer_sleep_o, .prox_irq_pending_o,
	.light_irq_pending_o, .int_n_o, .xfer_type_o
);

// File: dv/i2c_host_model.sv
`timescale 1ns/1ns

module i2c_host_model (
	input  wire logic ref_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// The bus idles released with the clock standing high.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Every change lands on a falling clock edge.
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// One bit: data set in the low phase, sampled in the middle of the high phase.
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = !b;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		r = sda_i;
		hold(8);
		scl_o = 1'b0;
		hold(8);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start;
		sda_low_o = 1'b0;
		hold(8);
		scl_o = 1'b1;
		hold(16);
		sda_low_o = 1'b1;
		hold(16);
		scl_o = 1'b0;
		hold(8);
	endtask

	// Stop: data rises while the clock is high, then the bus stands idle.
	task automatic stop;
		sda_low_o = 1'b1;
		hold(8);
		scl_o = 1'b1;
		hold(16);
		sda_low_o = 1'b0;
		hold(16);
	endtask

	// Eight bits MSB first and the acknowledge bit; send 0xff to read.
	task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r[i]);
		bit_io(a, ack);
	endtask

	function automatic logic [7:0] cmd_byte(input logic [1:0] kind, input logic [4:0] field);
		return {1'b1, kind, field};
	endfunction
endmodule

// File: dv/command_byte_and_enable_control_bench.sv
`timescale 1ns/1ns
`include "cmd_enable_defines.svh"

module command_byte_and_enable_control_bench;
	import cmd_enable_pkg::*;
	typedef logic [7:0] bytes_type[$];
	localparam int unsigned PD = 200;
	logic          ref_clk = 1'b0;
	logic          rst_n, scl, host_low, sda_bus, sda_o, sda_oe, prox_ev, light_ev, reg_wr;
	logic [4:0]    reg_addr;
	logic [7:0]    reg_wdata, reg_rdata;
	logic          osc_on, light_en, prox_en, wait_en, light_meas, prox_meas, seq_sleep;
	logic          prox_pend, light_pend, int_n;
	xfer_type_type xfer_type;
	logic [12:0]   wq[$];
	int            on_cnt = 0;
	int            n_fail = 0;
	int            samples_checked = 0;

	always #2 ref_clk = ~ref_clk;

	// Open-drain data line with a pull-up; outside registers answer with 101 above their five-bit address.
	assign sda_bus = !host_low && !(sda_oe && !sda_o);
	assign reg_rdata = {3'h5, reg_addr};

	// Logs outside register writes and time spent with the oscillator on.
	always @(posedge ref_clk) begin
		if (reg_wr === 1'b1)
			wq.push_back({reg_addr, reg_wdata});
		on_cnt <= (osc_on === 1'b1) ? on_cnt + 1 : 0;
	end

	i2c_host_model host_u (.ref_clk_i(ref_clk), .sda_i(sda_bus), .scl_o(scl), .sda_low_o(host_low));

	cmd_enable_ctrl #(.PON_DELAY_CYCLES(PD)) dut_u (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .prox_event_i(prox_ev), .light_event_i(light_ev),
		.reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
		.oscillator_power_on_o(osc_on), .light_function_enable_o(light_en),
		.prox_function_enable_o(prox_en), .wait_enable_o(wait_en),
		.ambient_light_measure_o(light_meas), .prox_measure_o(prox_meas),
		.sequencer_sleep_o(seq_sleep), .prox_irq_pending_o(prox_pend),
		.light_irq_pending_o(light_pend), .int_n_o(int_n), .xfer_type_o(xfer_type)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Sends one byte and expects the device to acknowledge it.
	task automatic send(input logic [7:0] b);
		logic [7:0] r;
		logic       a;
		host_u.xfer(b, 1'b1, r, a);
		chk(a, 1'b0);
	endtask

	task automatic put(input bytes_type q);
		host_u.start();
		send({`BUS_DEV_ADDR, 1'b0});
		foreach (q[i]) send(q[i]);
		host_u.stop();
	endtask

	// Command then repeated start and n read bytes, the last one refused.
	task automatic get(input logic [7:0] cmd, input int n, output bytes_type r);
		logic [7:0] b;
		logic       a;
		host_u.start();
		send({`BUS_DEV_ADDR, 1'b0});
		send(cmd);
		host_u.start();
		send({`BUS_DEV_ADDR, 1'b1});
		r = {};
		for (int i = 0; i < n; i++) begin
			host_u.xfer(8'hff, i == n - 1, b, a);
			r.push_back(b);
		end
		host_u.stop();
	endtask

	task automatic pulse;
		prox_ev = 1'b1;
		light_ev = 1'b1;
		@(negedge ref_clk);
		prox_ev = 1'b0;
		light_ev = 1'b0;
		host_u.hold(4);
	endtask

	task automatic t_reset;
		bytes_type r;
		chk({osc_on, light_en, prox_en, wait_en, prox_pend, light_pend, xfer_type}, 8'h00);
		chk({int_n, seq_sleep}, 2'h3);
		get(host_u.cmd_byte(`TYPE_REPEAT, 5'h00), 1, r);
		chk(r[0], 8'h00);
	endtask

	task automatic t_enable;
		bytes_type   r;
		logic [7:0] ev[5] = '{8'h3e, 8'h01, 8'h04, 8'h2a, 8'h00};
		foreach (ev[i]) begin
			put('{8'h80, ev[i]});
			chk({wait_en, prox_en, light_en, osc_on}, ev[i][3:0]);
			get(8'h80, 1, r);
			chk(r[0], ev[i]);
		end
	endtask

	task automatic t_seq;
		int n = 0;
		put('{8'h80, 8'h07});
		while (light_meas !== 1'b1 && n < 1000) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n < 1000, 1'b1);
		if (n >= 1000)
			close_out();
		chk(on_cnt >= PD && on_cnt <= PD + 3, 1'b1);
		chk({prox_meas, seq_sleep}, 2'h2);
		put('{8'h80, 8'h00});
		chk({seq_sleep, light_meas, prox_meas}, 3'h4);
	endtask

	task automatic t_ptr;
		bytes_type   r;
		logic [12:0] ew[5] = '{13'h0511, 13'h0522, 13'h1e33, 13'h1f44, 13'h0155};
		wq = {};
		put('{8'h85, 8'h11, 8'h22});
		put('{8'hbe, 8'h33, 8'h44, 8'h00});
		chk(xfer_type, `TYPE_AUTO_INC);
		put('{8'h55});
		chk(wq.size(), 5);
		foreach (ew[i]) chk(wq[i], ew[i]);
		get(8'h88, 2, r);
		chk({r[0], r[1]}, 16'ha8a8);
		get(8'hbf, 2, r);
		chk({r[0], r[1]}, 16'hbf00);
	endtask

	task automatic t_irq;
		logic [7:0] sc[4] = '{8'he0, 8'he5, 8'he6, 8'he7};
		logic [7:0] mk[3] = '{8'h00, 8'h20, 8'h10};
		foreach (mk[i]) begin
			put('{8'h80, mk[i]});
			pulse();
			chk({prox_pend, light_pend, int_n}, {mk[i][5], mk[i][4], mk[i][5:4] == 2'h0});
			put('{8'he7});
		end
		put('{8'h80, 8'h30});
		foreach (sc[i]) begin
			pulse();
			host_u.hold(300);
			chk({prox_pend, light_pend, int_n}, 3'h6);
			put('{sc[i]});
			chk({xfer_type, reg_addr}, {`TYPE_REPEAT, 5'h00});
			chk({prox_pend, light_pend}, {!(sc[i][2] & sc[i][0]), !(sc[i][2] & sc[i][1])});
			chk(int_n, sc[i][2:0] == 3'h7);
			put('{8'he7});
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		prox_ev = 1'b0;
		light_ev = 1'b0;
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_reset();
		t_enable();
		t_seq();
		t_ptr();
		t_irq();
		close_out();
	end
endmodule
